/* File: mcrb_pkg.sv */
/*
 * constants, field layouts and types for the meter configuration register bank.
 * assumes a single 50 MHz clock and a host register port decoded by page and address.
 */
package mcrb_pkg;

   localparam int CLK_HZ = 50_000_000;
   localparam int PULSE_TICK_HZ = 64_000;
   localparam int PULSE_BASE_US = 250;
   localparam logic [16:0] PULSE_BASE_TICKS = 17'(PULSE_BASE_US * PULSE_TICK_HZ / 1_000_000);
   localparam logic [14:0] PULSE_GAP_BASE = 15'h0020; // 64 kHz ticks, 2 kHz at band 0
   localparam logic [3:0] BAND_MAX = 4'h9;
   localparam int BAUD_ACC_W = 19; // 2^19 = 524288

   // register page and address
   localparam logic [5:0] PAGE_0 = 6'h00;
   localparam logic [5:0] PAGE_16 = 6'h10;
   localparam logic [5:0] PAGE_18 = 6'h12;
   localparam logic [5:0] ADDR_SERIAL_CTRL = 6'h07;
   localparam logic [5:0] ADDR_PULSE_WIDTH = 6'h08;
   localparam logic [5:0] ADDR_PULSE_SEL = 6'h09;
   localparam logic [5:0] ADDR_LOCK = 6'h22;
   localparam logic [5:0] ADDR_PHASE_SEQ = 6'h30;
   localparam logic [5:0] ADDR_CHECKSUM = 6'h01;
   localparam logic [5:0] ADDR_PULSE_RATE = 6'h1C;

   // reset values and writable masks
   localparam logic [23:0] SERIAL_CTRL_RST = 24'h02004D;
   localparam logic [23:0] SERIAL_CTRL_MASK = 24'h06FFFF;
   localparam logic [23:0] PULSE_WIDTH_RST = 24'h000001;
   localparam logic [23:0] PULSE_WIDTH_MASK = 24'h0FFFFF;
   localparam logic [23:0] PULSE_SEL_RST = 24'h000000;
   localparam logic [23:0] PULSE_SEL_MASK = 24'h000FFF;
   localparam logic [23:0] PULSE_RATE_RST = 24'h800000;

   // field positions
   localparam int RX_PULLUP_DISABLE_BIT = 18;
   localparam int RX_CHECKSUM_DISABLE_BIT = 17;
   localparam int BAND_LSB = 16;
   localparam int ENGINE_LOCK_LSB = 8;
   localparam int HOST_LOCK_LSB = 0;
   localparam int SEQ_DONE_BIT = 23;
   localparam int SEQ_COUNT_LSB = 16;
   localparam int SEQ_DIR_BIT = 5;
   localparam int SEQ_KEY_LSB = 0;

   // keys
   localparam logic [4:0] LOCK_KEY = 5'h16;
   localparam logic [4:0] UNLOCK_KEY = 5'h09;
   localparam logic [4:0] SEQ_START_KEY = 5'h16;
   localparam logic [6:0] SEQ_COUNT_MAX = 7'h7F;

   typedef enum logic [1:0] {
      MCRB_SEQ_IDLE = 2'b00,
      MCRB_SEQ_COUNT = 2'b01,
      MCRB_SEQ_DONE = 2'b10
   } mcrb_seq_state_t;

endpackage

/* File: mcrb_pulse_if.sv */
/*
 * carrier between the register bank and one energy pulse generator.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface mcrb_pulse_if;
   logic tick;
   logic req;
   logic [3:0] band;
   logic [15:0] width;
   logic pulse;

   modport ctrl (output tick, output req, output band, output width, input pulse);
   modport gen (input tick, input req, input band, input width, output pulse);
endinterface

/* File: mcrb_pulse_gen.sv */
/*
 * one energy pulse generator: stretches a request into a timed pulse and
 * enforces the minimum spacing of the selected frequency band.
 * assumes tick is a one-cycle 64 kHz enable.
 */
`timescale 1ns/1ps
module mcrb_pulse_gen
   import mcrb_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   mcrb_pulse_if.gen pif
);

   logic [16:0] dur_q;
   logic [16:0] dur_d;
   logic [14:0] gap_q;
   logic [14:0] gap_d;
   logic pulse_q;
   logic pulse_d;
   logic [3:0] band_eff;

   // reserved band codes act as the slowest band
   assign band_eff = (pif.band > BAND_MAX) ? BAND_MAX : pif.band;

   // duration and spacing counters
   always_comb
   begin
      dur_d = dur_q;
      gap_d = gap_q;
      if (pif.tick && dur_q != 17'h00000)
      begin
         dur_d = dur_q - 17'h00001;
      end
      if (pif.tick && gap_q != 15'h0000)
      begin
         gap_d = gap_q - 15'h0001;
      end
      if (pif.req && gap_q == 15'h0000)
      begin
         dur_d = PULSE_BASE_TICKS + {1'b0, pif.width};
         gap_d = PULSE_GAP_BASE << band_eff;
      end
      pulse_d = (dur_d != 17'h00000);
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         dur_q <= 17'h00000;
         gap_q <= 15'h0000;
         pulse_q <= 1'b0;
      end
      else
      begin
         dur_q <= dur_d;
         gap_q <= gap_d;
         pulse_q <= pulse_d;
      end
   end

   assign pif.pulse = pulse_q;

endmodule

/* File: mcrb_top.sv */
/*
 * meter configuration register bank: serial control, pulse width and band,
 * full-scale rate, pulse source select, write locks, phase sequence counter
 * and critical register checksum.
 * assumes the serial framing delivers decoded page, address and data strobes,
 * and the measurement datapath supplies sample ticks and zero crossings.
 */
`timescale 1ns/1ps
module mcrb_top
   import mcrb_pkg::*;
#(
   parameter int NUM_GEN = 3
)
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [5:0] reg_page_i,
   input wire logic [5:0] reg_addr_i,
   input wire logic [23:0] reg_wdata_i,
   output logic [23:0] reg_rdata_o,
   output logic reg_rvalid_o,
   input wire logic eng_wr_i,
   input wire logic [23:0] eng_wdata_i,
   input wire logic rx_frame_i,
   input wire logic rx_csum_mismatch_i,
   input wire logic rx_checksum_error_clr_i,
   output logic rx_checksum_error_o,
   output logic rx_pullup_disable_o,
   output logic rx_checksum_disable_o,
   output logic [15:0] bit_rate_divisor_o,
   output logic bit_tick_o,
   output logic signed [23:0] pulse_full_scale_rate_o,
   output logic [11:0] pulse_gen_source_o,
   output logic engine_write_lock_o,
   output logic host_write_lock_o,
   input wire logic output_word_rate_i,
   input wire logic vzc_rise_i,
   input wire logic vzc_fall_i,
   input wire logic [NUM_GEN-1:0] pulse_req_i,
   output logic [NUM_GEN-1:0] energy_pulse_o
);

   ////////////////////////////////////////////////////////////////////////////
   // register state

   logic [23:0] serial_port_control_q, serial_port_control_d;
   logic [23:0] energy_pulse_width_q, energy_pulse_width_d;
   logic [23:0] pulse_output_select_q, pulse_output_select_d;
   logic [23:0] pulse_full_scale_rate_q, pulse_full_scale_rate_d;
   logic host_lock_q, host_lock_d;
   logic engine_lock_q, engine_lock_d;
   logic rx_err_q, rx_err_d;
   logic [23:0] checksum_q, checksum_d;
   logic [23:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;

   logic wr_ok;
   logic sel_serial, sel_width, sel_select, sel_lock, sel_seq, sel_chk, sel_rate;
   logic [4:0] host_key, engine_key;

   // address decode
   assign sel_serial = (reg_page_i == PAGE_0) && (reg_addr_i == ADDR_SERIAL_CTRL);
   assign sel_width = (reg_page_i == PAGE_0) && (reg_addr_i == ADDR_PULSE_WIDTH);
   assign sel_select = (reg_page_i == PAGE_0) && (reg_addr_i == ADDR_PULSE_SEL);
   assign sel_lock = (reg_page_i == PAGE_0) && (reg_addr_i == ADDR_LOCK);
   assign sel_seq = (reg_page_i == PAGE_0) && (reg_addr_i == ADDR_PHASE_SEQ);
   assign sel_chk = (reg_page_i == PAGE_16) && (reg_addr_i == ADDR_CHECKSUM);
   assign sel_rate = (reg_page_i == PAGE_18) && (reg_addr_i == ADDR_PULSE_RATE);

   // host writes other than to the lock register pass only while the host lock is open
   assign wr_ok = reg_wr_i && !host_lock_q;
   assign host_key = reg_wdata_i[HOST_LOCK_LSB +: 5];
   assign engine_key = reg_wdata_i[ENGINE_LOCK_LSB +: 5];

   ////////////////////////////////////////////////////////////////////////////
   // phase sequence counter

   mcrb_seq_state_t seq_state_q, seq_state_d;
   logic [6:0] seq_count_q, seq_count_d;
   logic seq_dir_q, seq_dir_d;
   logic seq_start, seq_stop;

   assign seq_start = wr_ok && sel_seq
      && (reg_wdata_i[SEQ_KEY_LSB +: 5] == SEQ_START_KEY);
   assign seq_stop = seq_dir_q ? vzc_fall_i : vzc_rise_i;

   // sequence next state
   always_comb
   begin
      seq_state_d = seq_state_q;
      seq_count_d = seq_count_q;
      seq_dir_d = seq_dir_q;
      if (wr_ok && sel_seq)
      begin
         seq_dir_d = reg_wdata_i[SEQ_DIR_BIT];
      end
      case (seq_state_q)
         MCRB_SEQ_IDLE, MCRB_SEQ_DONE:
         begin
            seq_state_d = seq_state_q;
         end
         MCRB_SEQ_COUNT:
         begin
            if (seq_stop)
            begin
               seq_state_d = MCRB_SEQ_DONE;
            end
            else if (output_word_rate_i && seq_count_q != SEQ_COUNT_MAX)
            begin
               seq_count_d = seq_count_q + 7'h01;
            end
         end
         default:
         begin
            seq_state_d = MCRB_SEQ_IDLE;
         end
      endcase
      if (seq_start)
      begin
         seq_state_d = MCRB_SEQ_COUNT;
         seq_count_d = 7'h00;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         seq_state_q <= MCRB_SEQ_IDLE;
         seq_count_q <= 7'h00;
         seq_dir_q <= 1'b0;
      end
      else
      begin
         seq_state_q <= seq_state_d;
         seq_count_q <= seq_count_d;
         seq_dir_q <= seq_dir_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers, locks, error flag, checksum, read port

   always_comb
   begin
      serial_port_control_d = serial_port_control_q;
      energy_pulse_width_d = energy_pulse_width_q;
      pulse_output_select_d = pulse_output_select_q;
      pulse_full_scale_rate_d = pulse_full_scale_rate_q;
      host_lock_d = host_lock_q;
      engine_lock_d = engine_lock_q;
      // engine updates only while its lock is open; host write wins
      if (eng_wr_i && !engine_lock_q)
      begin
         pulse_full_scale_rate_d = eng_wdata_i;
      end
      if (wr_ok)
      begin
         if (sel_serial)
         begin
            serial_port_control_d = reg_wdata_i & SERIAL_CTRL_MASK;
         end
         if (sel_width)
         begin
            energy_pulse_width_d = reg_wdata_i & PULSE_WIDTH_MASK;
         end
         if (sel_select)
         begin
            pulse_output_select_d = reg_wdata_i & PULSE_SEL_MASK;
         end
         if (sel_rate)
         begin
            pulse_full_scale_rate_d = reg_wdata_i;
         end
      end
      // lock register stays writable while locked; other keys change nothing
      if (reg_wr_i && sel_lock)
      begin
         if (host_key == LOCK_KEY)
         begin
            host_lock_d = 1'b1;
         end
         else if (host_key == UNLOCK_KEY)
         begin
            host_lock_d = 1'b0;
         end
         if (engine_key == LOCK_KEY)
         begin
            engine_lock_d = 1'b1;
         end
         else if (engine_key == UNLOCK_KEY)
         begin
            engine_lock_d = 1'b0;
         end
      end
      // mismatch sets, and beats a clear in the same cycle
      rx_err_d = (rx_err_q && !rx_checksum_error_clr_i)
         || (rx_frame_i && rx_csum_mismatch_i
         && !serial_port_control_q[RX_CHECKSUM_DISABLE_BIT]);
      // additive checksum over the critical configuration words
      checksum_d = serial_port_control_q + energy_pulse_width_q
         + pulse_output_select_q + pulse_full_scale_rate_q;
      // read mux, unmapped and reserved bits read as zero
      rdata_d = 24'h000000;
      if (reg_rd_i)
      begin
         if (sel_serial)
         begin
            rdata_d = serial_port_control_q;
         end
         else if (sel_width)
         begin
            rdata_d = energy_pulse_width_q;
         end
         else if (sel_select)
         begin
            rdata_d = pulse_output_select_q;
         end
         else if (sel_rate)
         begin
            rdata_d = pulse_full_scale_rate_q;
         end
         else if (sel_lock)
         begin
            rdata_d[ENGINE_LOCK_LSB +: 5] = engine_lock_q ? LOCK_KEY : 5'h00;
            rdata_d[HOST_LOCK_LSB +: 5] = host_lock_q ? LOCK_KEY : 5'h00;
         end
         else if (sel_seq)
         begin
            rdata_d[SEQ_DONE_BIT] = (seq_state_q == MCRB_SEQ_DONE);
            rdata_d[SEQ_COUNT_LSB +: 7] = seq_count_q;
            rdata_d[SEQ_DIR_BIT] = seq_dir_q;
         end
         else if (sel_chk)
         begin
            rdata_d = checksum_q;
         end
      end
      rvalid_d = reg_rd_i;
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         serial_port_control_q <= SERIAL_CTRL_RST;
         energy_pulse_width_q <= PULSE_WIDTH_RST;
         pulse_output_select_q <= PULSE_SEL_RST;
         pulse_full_scale_rate_q <= PULSE_RATE_RST;
         host_lock_q <= 1'b0;
         engine_lock_q <= 1'b0;
         rx_err_q <= 1'b0;
         checksum_q <= 24'h000000;
         rdata_q <= 24'h000000;
         rvalid_q <= 1'b0;
      end
      else
      begin
         serial_port_control_q <= serial_port_control_d;
         energy_pulse_width_q <= energy_pulse_width_d;
         pulse_output_select_q <= pulse_output_select_d;
         pulse_full_scale_rate_q <= pulse_full_scale_rate_d;
         host_lock_q <= host_lock_d;
         engine_lock_q <= engine_lock_d;
         rx_err_q <= rx_err_d;
         checksum_q <= checksum_d;
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bit-rate and 64 kHz pulse timing

   logic [BAUD_ACC_W-1:0] baud_acc_q, baud_acc_d;
   logic bit_tick_q, bit_tick_d;
   logic [25:0] frac_acc_q, frac_acc_d;
   logic pulse_tick_q, pulse_tick_d;
   logic [BAUD_ACC_W:0] baud_sum;

   // divisor accumulates per clock; carry out of 2^19 marks one bit time
   assign baud_sum = {1'b0, baud_acc_q}
      + {4'h0, serial_port_control_q[15:0]};

   always_comb
   begin
      baud_acc_d = baud_sum[BAUD_ACC_W-1:0];
      bit_tick_d = baud_sum[BAUD_ACC_W];
      // fractional divider, 64000 per second on average
      if (frac_acc_q >= 26'(CLK_HZ - PULSE_TICK_HZ))
      begin
         frac_acc_d = frac_acc_q + 26'(PULSE_TICK_HZ) - 26'(CLK_HZ);
         pulse_tick_d = 1'b1;
      end
      else
      begin
         frac_acc_d = frac_acc_q + 26'(PULSE_TICK_HZ);
         pulse_tick_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         baud_acc_q <= '0;
         bit_tick_q <= 1'b0;
         frac_acc_q <= 26'h0000000;
         pulse_tick_q <= 1'b0;
      end
      else
      begin
         baud_acc_q <= baud_acc_d;
         bit_tick_q <= bit_tick_d;
         frac_acc_q <= frac_acc_d;
         pulse_tick_q <= pulse_tick_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // energy pulse generators

   genvar g;
   generate
      for (g = 0; g < NUM_GEN; g++)
      begin : gen_pulse
         mcrb_pulse_if pif ();
         assign pif.tick = pulse_tick_q;
         assign pif.req = pulse_req_i[g];
         assign pif.band = energy_pulse_width_q[BAND_LSB +: 4];
         assign pif.width = energy_pulse_width_q[15:0];
         assign energy_pulse_o[g] = pif.pulse;
         mcrb_pulse_gen u_gen (
            .clk_i (clk_i),
            .reset_i (reset_i),
            .pif (pif.gen)
         );
      end
   endgenerate

   // outputs
   assign reg_rdata_o = rdata_q;
   assign reg_rvalid_o = rvalid_q;
   assign rx_checksum_error_o = rx_err_q;
   assign rx_pullup_disable_o = serial_port_control_q[RX_PULLUP_DISABLE_BIT];
   assign rx_checksum_disable_o = serial_port_control_q[RX_CHECKSUM_DISABLE_BIT];
   assign bit_rate_divisor_o = serial_port_control_q[15:0];
   assign bit_tick_o = bit_tick_q;
   assign pulse_full_scale_rate_o = pulse_full_scale_rate_q;
   assign pulse_gen_source_o = pulse_output_select_q[11:0];
   assign engine_write_lock_o = engine_lock_q;
   assign host_write_lock_o = host_lock_q;

endmodule

/* File: mcrb_checker.sv */
/*
 * concurrent checks on the ports of the meter configuration register bank.
 * assumes it is bound onto mcrb_top and shares its single clock and reset.
 */
`timescale 1ns/1ps
module mcrb_checker
   import mcrb_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [5:0] reg_page_i,
   input wire logic [5:0] reg_addr_i,
   input wire logic [23:0] reg_wdata_i,
   input wire logic [23:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   input wire logic eng_wr_i,
   input wire logic [23:0] eng_wdata_i,
   input wire logic rx_frame_i,
   input wire logic rx_csum_mismatch_i,
   input wire logic rx_checksum_error_o,
   input wire logic rx_pullup_disable_o,
   input wire logic rx_checksum_disable_o,
   input wire logic [15:0] bit_rate_divisor_o,
   input wire logic signed [23:0] pulse_full_scale_rate_o,
   input wire logic [11:0] pulse_gen_source_o,
   input wire logic engine_write_lock_o,
   input wire logic host_write_lock_o
);
   logic wr_ok;
   logic lock_wr;

   // host writes that reach page 0, with and without the lock word
   assign wr_ok = reg_wr_i && !host_write_lock_o && reg_page_i == PAGE_0;
   assign lock_wr = reg_wr_i && reg_page_i == PAGE_0 && reg_addr_i == ADDR_LOCK;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   ////////////////////////////////////////////////////////////////////////////////
   a_read_answer: assert property (reg_rd_i ##1 !reg_rd_i |-> reg_rvalid_o ##1 !reg_rvalid_o)
      else $error("read answer pulse wrong");
   a_rdata_idle: assert property (!reg_rvalid_o |-> reg_rdata_o == 24'h000000)
      else $error("read data not zero while idle");
   a_serial_write: assert property (wr_ok
      && reg_addr_i == ADDR_SERIAL_CTRL |=>
      {rx_pullup_disable_o, rx_checksum_disable_o, bit_rate_divisor_o} ==
      {$past(reg_wdata_i[18:17]), $past(reg_wdata_i[15:0])})
      else $error("serial control outputs do not follow write");
   a_select_write: assert property (wr_ok && reg_addr_i == ADDR_PULSE_SEL |=>
      pulse_gen_source_o == $past(reg_wdata_i[11:0]))
      else $error("source select does not follow write");
   a_host_lock: assert property (reg_wr_i && host_write_lock_o && !lock_wr |=>
      $stable(bit_rate_divisor_o) && $stable(pulse_gen_source_o))
      else $error("write passed the host lock");
   a_lock_key: assert property (lock_wr |=> host_write_lock_o ==
      ($past(reg_wdata_i[4:0]) == LOCK_KEY ||
      ($past(host_write_lock_o) && $past(reg_wdata_i[4:0]) != UNLOCK_KEY)))
      else $error("host lock state wrong after key write");
   a_engine_lock: assert property (engine_write_lock_o && eng_wr_i && !reg_wr_i |=>
      $stable(pulse_full_scale_rate_o))
      else $error("engine write passed the lock");
   a_engine_write: assert property (!engine_write_lock_o && eng_wr_i && !reg_wr_i |=>
      pulse_full_scale_rate_o == $past(eng_wdata_i))
      else $error("engine write not taken");
   a_err_set: assert property (rx_frame_i && rx_csum_mismatch_i
      && !rx_checksum_disable_o |=> rx_checksum_error_o)
      else $error("checksum error flag not set");
   a_err_quiet: assert property (!rx_checksum_error_o &&
      (rx_checksum_disable_o || !rx_frame_i || !rx_csum_mismatch_i) |=> !rx_checksum_error_o)
      else $error("checksum error flag set without cause");

   // main scenarios reached
   c_read: cover property (reg_rd_i ##1 reg_rvalid_o);
   c_err: cover property (rx_checksum_error_o);
   c_lock: cover property ($rose(host_write_lock_o));
endmodule

bind mcrb_top mcrb_checker u_mcrb_checker (.*);

/* File: mcrb_host_model.sv */
/*
 * host controller model: issues register writes and reads on the decoded port.
 * assumes tasks are entered just after a falling clock edge.
 */
`timescale 1ns/1ps
module mcrb_host_model
(
   input wire logic clk_i,
   output logic wr_o,
   output logic rd_o,
   output logic [5:0] page_o,
   output logic [5:0] addr_o,
   output logic [23:0] wdata_o,
   input wire logic [23:0] rdata_i,
   input wire logic rvalid_i
);
   // idle port at time zero
   initial
   begin
      wr_o = 0;
      rd_o = 0;
      page_o = 6'h00;
      addr_o = 6'h00;
      wdata_o = 24'h000000;
   end

   // one write strobe; data inverted once released, then one idle edge
   task automatic wr(input logic [5:0] p, input logic [5:0] a, input logic [23:0] d);
      page_o = p;
      addr_o = a;
      wdata_o = d;
      wr_o = 1;
      @(negedge clk_i);
      wr_o = 0;
      wdata_o = ~d;
      @(negedge clk_i);
   endtask

   // one read strobe, answer awaited for a few cycles at most
   task automatic rd(input logic [5:0] p, input logic [5:0] a, output logic [23:0] d,
                     output bit ok);
      page_o = p;
      addr_o = a;
      rd_o = 1;
      @(negedge clk_i);
      rd_o = 0;
      ok = 0;
      d = 'x;
      for (int i = 0; i < 4 && !ok; i++)
      begin
         if (rvalid_i === 1'b1)
         begin
            ok = 1;
            d = rdata_i;
         end
         else
            @(negedge clk_i);
      end
      @(negedge clk_i);
   endtask
endmodule

/* File: test_meter_config_register_bank.sv */
/*
 * self-checking bench for the meter configuration register bank.
 * assumes mcrb_top, the host model and the bound checker are compiled with it.
 */
`timescale 1ns/1ps
module test_meter_config_register_bank;
   import mcrb_pkg::*;
   logic clk_i = 0;
   logic reset_i = 1;
   logic reg_wr_i, reg_rd_i, reg_rvalid_o, bit_tick_o, engine_write_lock_o, host_write_lock_o;
   logic eng_wr_i = 0, rx_frame_i = 0, rx_csum_mismatch_i = 0, rx_checksum_error_clr_i = 0;
   logic output_word_rate_i = 0, vzc_rise_i = 0, vzc_fall_i = 0;
   logic rx_checksum_error_o, rx_pullup_disable_o, rx_checksum_disable_o;
   logic [5:0] reg_page_i, reg_addr_i;
   logic [23:0] reg_wdata_i, reg_rdata_o, eng_wdata_i = 0, m_ser, m_pw, m_sel, m_rate;
   logic [15:0] bit_rate_divisor_o;
   logic signed [23:0] pulse_full_scale_rate_o;
   logic [11:0] pulse_gen_source_o;
   logic [2:0] pulse_req_i = 0, energy_pulse_o;
   int n_errors = 0, n_checks = 0, hl = 0, el = 0;
   logic [11:0] regs [7] = '{{PAGE_0, ADDR_SERIAL_CTRL}, {PAGE_0, ADDR_PULSE_WIDTH},
      {PAGE_0, ADDR_PULSE_SEL}, {PAGE_18, ADDR_PULSE_RATE}, {PAGE_0, ADDR_LOCK},
      {PAGE_16, ADDR_CHECKSUM}, {PAGE_0, 6'h3F}};

   // 50 MHz clock
   always #10 clk_i = ~clk_i;

   mcrb_top u_mcrb_top (.*);
   mcrb_host_model u_mcrb_host_model (.clk_i(clk_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
      .page_o(reg_page_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i),
      .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(string what, logic [23:0] e, logic [23:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask

   // expected read value of a register from the model
   function automatic logic [23:0] ev(logic [11:0] r);
      logic [5:0] p, a;
      {p, a} = r;
      if (p == PAGE_0 && a == ADDR_SERIAL_CTRL) return m_ser;
      if (p == PAGE_0 && a == ADDR_PULSE_WIDTH) return m_pw;
      if (p == PAGE_0 && a == ADDR_PULSE_SEL) return m_sel;
      if (p == PAGE_18 && a == ADDR_PULSE_RATE) return m_rate;
      if (p == PAGE_16 && a == ADDR_CHECKSUM) return m_ser + m_pw + m_sel + m_rate;
      if (p == PAGE_0 && a == ADDR_LOCK) return {11'h000, el ? LOCK_KEY : 5'h00, 3'h0,
         hl ? LOCK_KEY : 5'h00};
      return 24'h000000;
   endfunction

   // host write, mirrored in the model first
   task automatic hw(logic [5:0] p, logic [5:0] a, logic [23:0] d);
      if (p == PAGE_0 && a == ADDR_LOCK)
      begin
         hl = d[4:0] == LOCK_KEY ? 1 : d[4:0] == UNLOCK_KEY ? 0 : hl;
         el = d[12:8] == LOCK_KEY ? 1 : d[12:8] == UNLOCK_KEY ? 0 : el;
      end
      else if (!hl)
      begin
         if (p == PAGE_0 && a == ADDR_SERIAL_CTRL) m_ser = d & SERIAL_CTRL_MASK;
         if (p == PAGE_0 && a == ADDR_PULSE_WIDTH) m_pw = d & PULSE_WIDTH_MASK;
         if (p == PAGE_0 && a == ADDR_PULSE_SEL) m_sel = d & PULSE_SEL_MASK;
         if (p == PAGE_18 && a == ADDR_PULSE_RATE) m_rate = d;
      end
      u_mcrb_host_model.wr(p, a, d);
   endtask

   task automatic rc(logic [5:0] p, logic [5:0] a, logic [23:0] e);
      logic [23:0] d;
      bit ok;
      u_mcrb_host_model.rd(p, a, d, ok);
      if (!ok)
      begin
         n_errors++;
         $display("CHECK FAILED rvalid expected 1 seen 0");
         give_verdict();
      end
      else
         chk("rdata", e, d);
   endtask

   task automatic rc_all;
      for (int i = 0; i < 7; i++)
         rc(regs[i][11:6], regs[i][5:0], ev(regs[i]));
   endtask

   task automatic chk_out;
      chk("pullup", 24'(m_ser[18]), 24'(rx_pullup_disable_o));
      chk("csum off", 24'(m_ser[17]), 24'(rx_checksum_disable_o));
      chk("divisor", 24'(m_ser[15:0]), 24'(bit_rate_divisor_o));
      chk("source", 24'(m_sel[11:0]), 24'(pulse_gen_source_o));
      chk("rate", m_rate, pulse_full_scale_rate_o);
   endtask

   task automatic pul(ref logic s);
      s = 1;
      @(negedge clk_i);
      s = 0;
      @(negedge clk_i);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      int n;
      logic [23:0] v;
      n = $urandom(94778);
      m_ser = SERIAL_CTRL_RST;
      m_pw = PULSE_WIDTH_RST;
      m_sel = PULSE_SEL_RST;
      m_rate = PULSE_RATE_RST;
      repeat (20) @(negedge clk_i);
      reset_i = 0;
      rc_all();
      chk_out();
      $display("test reset values done");
      repeat (3) for (int i = 0; i < 4; i++)
      begin
         v = 24'($urandom);
         if (i == 1 && v[15:0] == 16'h0000) v[0] = 1;
         hw(regs[i][11:6], regs[i][5:0], v);
      end
      rc_all();
      chk_out();
      $display("test random writes done");
      hw(PAGE_0, ADDR_SERIAL_CTRL, 24'(64'(3_125_000) * 524288 / CLK_HZ));
      n = 0;
      repeat (320)
      begin
         @(negedge clk_i);
         n += int'(bit_tick_o === 1'b1);
      end
      chk("bit ticks", 24'h000014, 24'(n));
      $display("test bit timing done");
      rx_csum_mismatch_i = 1;
      pul(rx_frame_i);
      chk("csum err", 24'h000001, 24'(rx_checksum_error_o));
      pul(rx_checksum_error_clr_i);
      chk("csum err", 24'h000000, 24'(rx_checksum_error_o));
      hw(PAGE_0, ADDR_SERIAL_CTRL, 24'h028000);
      pul(rx_frame_i);
      chk("csum err", 24'h000000, 24'(rx_checksum_error_o));
      rx_csum_mismatch_i = 0;
      $display("test checksum error done");
      for (int k = 0; k < 2; k++)
      begin
         if (k) hw(PAGE_0, ADDR_LOCK, 24'h001600);
         v = 24'($urandom);
         eng_wdata_i = v;
         pul(eng_wr_i);
         if (!k) m_rate = v;
         chk("engine rate", m_rate, pulse_full_scale_rate_o);
      end
      chk("engine lock", 24'h000001, 24'(engine_write_lock_o));
      hw(PAGE_0, ADDR_LOCK, 24'h000900);
      chk("engine lock", 24'h000000, 24'(engine_write_lock_o));
      $display("test engine lock done");
      hw(PAGE_0, ADDR_LOCK, 24'h000016);
      hw(PAGE_0, ADDR_PULSE_SEL, 24'h000ABC);
      hw(PAGE_0, ADDR_LOCK, 24'h00000F);
      hw(PAGE_0, ADDR_SERIAL_CTRL, 24'h040000);
      rc_all();
      chk("host lock", 24'h000001, 24'(host_write_lock_o));
      hw(PAGE_0, ADDR_LOCK, 24'h000009);
      chk("host lock", 24'h000000, 24'(host_write_lock_o));
      chk_out();
      $display("test host lock done");
      for (int d = 0; d < 2; d++)
      begin
         hw(PAGE_0, ADDR_PHASE_SEQ, 24'(d << 5) | 24'h000016);
         repeat (3 + d) pul(output_word_rate_i);
         if (d) pul(vzc_rise_i); else pul(vzc_fall_i);
         pul(output_word_rate_i);
         if (d) pul(vzc_fall_i); else pul(vzc_rise_i);
         pul(output_word_rate_i);
         v = 24'h800000 | 24'((4 + d) << 16) | 24'(d << 5);
         rc(PAGE_0, ADDR_PHASE_SEQ, v);
      end
      $display("test phase sequence done");
      hw(PAGE_0, ADDR_PULSE_WIDTH, 24'h000001);
      pulse_req_i = 3'b111;
      @(negedge clk_i);
      pulse_req_i = 3'b000;
      chk("pulses", 24'h000007, 24'(energy_pulse_o));
      n = 0;
      while (n < 20000 && energy_pulse_o[0] === 1'b1)
      begin
         @(negedge clk_i);
         n++;
      end
      chk("pulse length", 24'h000001, 24'(n > 16 * 781 && n < 18 * 782));
      pulse_req_i = 3'b001;
      @(negedge clk_i);
      pulse_req_i = 3'b000;
      chk("early pulse", 24'h000000, 24'(energy_pulse_o));
      repeat (13000) @(negedge clk_i);
      pulse_req_i = 3'b001;
      @(negedge clk_i);
      pulse_req_i = 3'b000;
      chk("late pulse", 24'h000001, 24'(energy_pulse_o[0]));
      $display("test pulse spacing done");
      give_verdict();
   end
endmodule
